// file: core/serial_frame_input.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - with frame select low, sample serial data on every falling serial clock edge.
// - sixteen-bit shift register, shifting only on edges after frame select falls.
// - frame select rising after sixteen or more falling edges commits the word.
// - frame select rising before the sixteenth falling edge discards the frame.
// - serial output shows valid data only after more than sixteen clocks.
// - serial output feeds the next device's serial input directly in a chain.
module serial_frame_input
  import serial_frame_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_BITS
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              sclk,
  input  wire logic              frame_n,
  input  wire logic              sdata_in,
  output logic                   sdata_out,
  output logic                   sdata_out_valid,
  output logic [WIDTH-1:0]       word_out,
  output logic                   word_strobe
);

  if (WIDTH != WORD_BITS) begin : g_width_check
    $error("serial_frame_input supports only a 16-bit word");
  end

  // --------------------------------------------------------------
  // link domain, clocked by the falling serial clock
  // --------------------------------------------------------------
  // a high frame only arms a restart of the count; the first falling edge of
  // the next frame performs it. the finished count and word therefore stay
  // put after the frame ends, which is where the system side reads them.
  // clearing the count on the rise itself would race the synchroniser and
  // lose every commit.
  logic [WIDTH-1:0]    shift_q;
  logic [WIDTH-1:0]    shift_d;
  logic [CNT_BITS-1:0] cnt_q;
  logic [CNT_BITS-1:0] cnt_d;
  logic                out_q;
  logic                out_d;
  logic                fresh_q;
  logic                fresh_d;

  always_comb begin
    shift_d = {shift_q[WIDTH-2:0], sdata_in};
    out_d   = shift_q[WIDTH-1];
    fresh_d = 1'b0;
    if (fresh_q) begin
      cnt_d = 5'h01;
    end else if (cnt_q == 5'h1F) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  // the restart flag is set asynchronously, since sclk may stop between frames
  always_ff @(negedge sclk or negedge reset_n or posedge frame_n) begin
    if (!reset_n) begin
      fresh_q <= 1'b1;
    end else if (frame_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= fresh_d;
    end
  end

  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= WORD_RESET;
      out_q   <= 1'b0;
      cnt_q   <= CNT_RESET;
    end else if (!frame_n) begin
      shift_q <= shift_d;
      out_q   <= out_d;
      cnt_q   <= cnt_d;
    end
  end

  // valid only while framed and past the sixteenth clock
  logic out_ok;
  always_comb begin
    out_ok = !frame_n && !fresh_q && (cnt_q > CNT_FULL);
  end

  // --------------------------------------------------------------
  // system domain: frame edge via two-stage synchroniser
  // --------------------------------------------------------------
  // the link domain is quiet once frame_n is high, so shift_q and cnt_q are
  // stable when the synchronised rise is seen; sampling them here is safe.
  // limitation: the host must keep frame_n high three system clocks between
  // frames, or the next frame's first edge may move the count too early.
  logic [1:0]       fsync_q;
  logic [1:0]       fsync_d;
  logic             fprev_q;
  logic             fprev_d;
  logic [WIDTH-1:0] word_q;
  logic [WIDTH-1:0] word_d;
  logic             strobe_q;
  logic             strobe_d;
  logic [CNT_BITS-1:0] seen_q;
  logic [CNT_BITS-1:0] seen_d;
  logic             rise;

  always_comb begin
    fsync_d  = {fsync_q[0], frame_n};
    fprev_d  = fsync_q[1];
    rise     = fsync_q[1] && !fprev_q;
    word_d   = word_q;
    strobe_d = 1'b0;
    seen_d   = seen_q;
    if (rise) begin
      seen_d = cnt_q;
      if (cnt_q >= CNT_FULL) begin
        word_d   = shift_q;
        strobe_d = 1'b1;
      end
      // fewer edges: word_q untouched, frame dropped
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fsync_q  <= 2'b11;
      fprev_q  <= 1'b1;
      word_q   <= WORD_RESET;
      strobe_q <= 1'b0;
      seen_q   <= CNT_RESET;
    end else begin
      fsync_q  <= fsync_d;
      fprev_q  <= fprev_d;
      word_q   <= word_d;
      strobe_q <= strobe_d;
      seen_q   <= seen_d;
    end
  end

  // the chain output itself stays on the link clock so a daisy chain keeps
  // its timing; it is held low outside a frame of more than sixteen clocks.
  always_comb begin
    sdata_out       = out_ok ? out_q : 1'b0;
    sdata_out_valid = out_ok;
    word_out        = word_q;
    word_strobe     = strobe_q;
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------

  property p_shift_in;
    @(negedge sclk) disable iff (!reset_n)
      !frame_n |=> shift_q[0] == $past(sdata_in);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not captured");

  property p_no_shift_idle;
    @(negedge sclk) disable iff (!reset_n)
      frame_n |=> $stable(shift_q);
  endproperty
  a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift outside frame");

  property p_commit;
    @(posedge clk_sys) disable iff (!reset_n)
      rise && cnt_q >= CNT_FULL |=> word_strobe && word_out == $past(shift_q);
  endproperty
  a_commit: assert property (p_commit) else $error("word not committed");

  property p_abort;
    @(posedge clk_sys) disable iff (!reset_n)
      rise && cnt_q < CNT_ABORT |=> !word_strobe && $stable(word_out);
  endproperty
  a_abort: assert property (p_abort) else $error("short frame applied");

  property p_out_gate;
    @(negedge sclk) disable iff (!reset_n)
      cnt_q <= CNT_FULL |-> !sdata_out_valid;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output valid too early");

  property p_far_end;
    @(negedge sclk) disable iff (!reset_n)
      !frame_n |=> out_q == $past(shift_q[WIDTH-1]);
  endproperty
  a_far_end: assert property (p_far_end) else $error("output not far end bit");

  property p_strobe_pulse;
    @(posedge clk_sys) disable iff (!reset_n)
      word_strobe |=> !word_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");

  property p_word_only_on_strobe;
    @(posedge clk_sys) disable iff (!reset_n)
      !word_strobe |-> word_out == $past(word_out) || $past(!reset_n);
  endproperty
  a_word_only_on_strobe: assert property (p_word_only_on_strobe) else $error("word changed");

  property p_fresh_restart;
    @(negedge sclk) disable iff (!reset_n)
      fresh_q && !frame_n |=> cnt_q == 5'h01;
  endproperty
  a_fresh_restart: assert property (p_fresh_restart) else $error("count not restarted");

  property p_count_step;
    @(negedge sclk) disable iff (!reset_n)
      !fresh_q && !frame_n && cnt_q != 5'h1F |=> cnt_q == $past(cnt_q) + 5'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("edge not counted");

  property p_count_hold_idle;
    @(negedge sclk) disable iff (!reset_n)
      frame_n |=> $stable(cnt_q);
  endproperty
  a_count_hold_idle: assert property (p_count_hold_idle) else $error("count moved idle");

  // one check per register stage above bit 0, so a broken link is named by its position
  for (genvar i = 1; i < WIDTH; i++) begin : g_shift_chk
    property p_shift_bit;
      @(negedge sclk) disable iff (!reset_n)
        !frame_n |=> shift_q[i] == $past(shift_q[i-1]);
    endproperty
    a_shift_bit: assert property (p_shift_bit) else $error("shift chain broken");
  end

  property p_valid_on;
    @(negedge sclk) disable iff (!reset_n)
      !frame_n && !fresh_q && cnt_q > CNT_FULL |-> sdata_out_valid;
  endproperty
  a_valid_on: assert property (p_valid_on) else $error("output not valid");

  property p_idle_invalid;
    @(posedge clk_sys) disable iff (!reset_n)
      frame_n |-> !sdata_out_valid;
  endproperty
  a_idle_invalid: assert property (p_idle_invalid) else $error("valid outside frame");

  property p_valid_fresh;
    @(posedge clk_sys) disable iff (!reset_n)
      fresh_q |-> !sdata_out_valid;
  endproperty
  a_valid_fresh: assert property (p_valid_fresh) else $error("stale count shown");

  property p_out_zero;
    @(posedge clk_sys) disable iff (!reset_n)
      !sdata_out_valid |-> !sdata_out;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("output not held low");

  property p_chain_pass;
    @(negedge sclk) disable iff (!reset_n)
      sdata_out_valid |-> sdata_out == out_q;
  endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("chain bit lost");

  property p_strobe_needs_count;
    @(posedge clk_sys) disable iff (!reset_n)
      word_strobe |-> seen_q >= CNT_FULL;
  endproperty
  a_strobe_needs_count: assert property (p_strobe_needs_count) else $error("short commit");

  property p_strobe_after_rise;
    @(posedge clk_sys) disable iff (!reset_n)
      word_strobe |-> $past(rise);
  endproperty
  a_strobe_after_rise: assert property (p_strobe_after_rise) else $error("stray strobe");

  property p_strobe_framed_off;
    @(posedge clk_sys) disable iff (!reset_n)
      word_strobe |-> fsync_q[1];
  endproperty
  a_strobe_framed_off: assert property (p_strobe_framed_off) else $error("strobe in frame");

  property p_rise_single;
    @(posedge clk_sys) disable iff (!reset_n)
      rise |=> !rise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("double frame edge");

  property p_link_frozen;
    @(posedge clk_sys) disable iff (!reset_n)
      rise |-> $stable(shift_q) && $stable(cnt_q);
  endproperty
  a_link_frozen: assert property (p_link_frozen) else $error("link moved at commit");

  property p_abort_fifteen;
    @(posedge clk_sys) disable iff (!reset_n)
      rise && cnt_q == CNT_ABORT |=> !word_strobe;
  endproperty
  a_abort_fifteen: assert property (p_abort_fifteen) else $error("15-edge frame applied");

  // --------------------------------------------------------------
  // cover properties
  // --------------------------------------------------------------
  c_commit: cover property (@(posedge clk_sys) disable iff (!reset_n) word_strobe);
  c_abort: cover property (@(posedge clk_sys) disable iff (!reset_n) rise && cnt_q < CNT_ABORT);
  c_abort15: cover property (@(posedge clk_sys) disable iff (!reset_n) rise && cnt_q == CNT_ABORT);
  c_chain: cover property (@(negedge sclk) disable iff (!reset_n) sdata_out_valid);
  c_long: cover property (@(posedge clk_sys) disable iff (!reset_n) rise && cnt_q > CNT_FULL);

endmodule

`default_nettype wire

// file: core/serial_frame_pkg.sv
package serial_frame_pkg;
  // --------------------------------------------------------------
  // word and frame geometry
  // --------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned ABORT_EDGES = 15;
  localparam int unsigned CNT_BITS    = 5;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [4:0]  CNT_RESET   = 5'h00;
  localparam logic [4:0]  CNT_FULL    = 5'h10;
  localparam logic [4:0]  CNT_ABORT   = 5'h0F;
endpackage

// file: verif/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  output logic      sclk,
  output logic      frame_n,
  output logic      sdata,
  input  wire logic sdata_out,
  input  wire logic sdata_out_valid
);
  logic [15:0] echo_q;
  int          echo_n;
  initial begin
    sclk    = 1'b1;
    frame_n = 1'b1;
    sdata   = 1'b0;
    echo_q  = 16'h0000;
  end
  // --------------------------------------------------------------
  // frame driver: msb first, data set while sclk high
  // --------------------------------------------------------------
  task automatic send(input logic [31:0] bits, input int n);
    echo_n  = 0;
    frame_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata = bits[i];
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    #40 frame_n = 1'b1;
    // released line: show the inverse, never the stale bit
    sdata = ~sdata;
  endtask
  // chained bits as a downstream device would see them
  always @(posedge sclk) begin
    if (sdata_out_valid === 1'b1) begin
      echo_q = {echo_q[14:0], sdata_out};
      echo_n = echo_n + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/serial_frame_input_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_frame_input_tb_top;
  logic        clk_sys, reset_n, sclk, frame_n, sdata_in;
  logic        sdata_out, sdata_out_valid, word_strobe;
  logic [15:0] word_out;
  int          errors, checks, strobes;
  serial_frame_input u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .sclk(sclk),
    .frame_n(frame_n), .sdata_in(sdata_in), .sdata_out(sdata_out),
    .sdata_out_valid(sdata_out_valid), .word_out(word_out), .word_strobe(word_strobe));
  serial_host_model u_host (.sclk(sclk), .frame_n(frame_n), .sdata(sdata_in),
    .sdata_out(sdata_out), .sdata_out_valid(sdata_out_valid));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (word_strobe === 1'b1) strobes++;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // frame plus a settle span well past the three-cycle commit latency
  task automatic do_frame(input logic [31:0] bits, input int n);
    strobes = 0;
    u_host.send(bits, n);
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic t_commit();
    do_frame(32'h0000_C3A5, 16);
    check("strobes", 16'(strobes), 16'h0001);
    check("word", word_out, 16'hC3A5);
    check("chain_n", 16'(u_host.echo_n), 16'h0000);
  endtask
  task automatic t_abort();
    for (int n = 14; n <= 15; n++) begin
      do_frame(32'h0000_5A5A, n);
      check("abort_strobes", 16'(strobes), 16'h0000);
      check("abort_word", word_out, 16'hC3A5);
    end
  endtask
  task automatic t_long();
    do_frame(32'h00A5_0F0F, 24);
    check("long_word", word_out, 16'h0F0F);
    check("chain_bits", {8'h00, u_host.echo_q[7:0]}, 16'h00A5);
    check("chain_n", 16'(u_host.echo_n), 16'h0008);
    do_frame(32'h0001_8001, 17);
    check("edge17_n", 16'(u_host.echo_n), 16'h0001);
    check("edge17_word", word_out, 16'h8001);
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    errors  = 0;
    checks  = 0;
    strobes = 0;
    reset_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    check("reset_word", word_out, 16'h0000);
    t_commit();
    t_abort();
    t_long();
    finish_test();
  end
  initial begin
    #100us;
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
